// ==== tmr8_consts.vh ====
/*
  Register offsets, field positions, reset values and encodings of the
  8-bit timer/counter with two compare channels.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------
`define TMR8_OFF_CTRL_A   12'h000
`define TMR8_OFF_CTRL_B   12'h004
`define TMR8_OFF_COUNT    12'h008
`define TMR8_OFF_CMP_A    12'h00C
`define TMR8_OFF_CMP_B    12'h010
`define TMR8_OFF_MASK     12'h014
`define TMR8_OFF_FLAGS    12'h018
`define TMR8_OFF_GIE      12'h01C
`define TMR8_OFF_VACK     12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR8_B_FOC_A      7
`define TMR8_B_FOC_B      6
`define TMR8_B_WGM_HI     3
`define TMR8_BIT_CMPB     2
`define TMR8_BIT_CMPA     1
`define TMR8_BIT_OVF      0
`define TMR8_CTRLB_RMASK  8'h0F
`define TMR8_CTRLA_RMASK  8'hF3
`define TMR8_IRQ_RMASK    8'h07

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR8_RST_BYTE     8'h00

// ----------------------------------------------------------------
// Counting constants
// ----------------------------------------------------------------
`define TMR8_MAX          8'hFF
`define TMR8_BOTTOM       8'h00
`define TMR8_PRE_W        10
`define TMR8_PRE_MAX      10'h3FF

// ----------------------------------------------------------------
// Clock select codes
// ----------------------------------------------------------------
`define TMR8_CS_STOP      3'h0
`define TMR8_CS_DIV1      3'h1
`define TMR8_CS_DIV8      3'h2
`define TMR8_CS_DIV64     3'h3
`define TMR8_CS_DIV256    3'h4
`define TMR8_CS_DIV1024   3'h5
`define TMR8_CS_EXT_FALL  3'h6
`define TMR8_CS_EXT_RISE  3'h7

// ----------------------------------------------------------------
// Waveform modes
// ----------------------------------------------------------------
`define TMR8_WM_NORMAL    3'h0
`define TMR8_WM_PC_FF     3'h1
`define TMR8_WM_CTC       3'h2
`define TMR8_WM_FAST_FF   3'h3
`define TMR8_WM_PC_CMP    3'h5
`define TMR8_WM_FAST_CMP  3'h7

// ----------------------------------------------------------------
// Output action codes
// ----------------------------------------------------------------
`define TMR8_ACT_OFF      2'h0
`define TMR8_ACT_TOGGLE   2'h1
`define TMR8_ACT_CLEAR    2'h2
`define TMR8_ACT_SET      2'h3

`endif

// ==== tmr8_timer.v ====
/*
  8-bit timer/counter: clock select and prescaler, external pin clock,
  counter, two compare channels with waveform outputs, force strobes,
  interrupt mask and flags, APB register slave.
  Assumes a single pclk domain; the external pin is asynchronous.
*/
// How it works
// - Force A bit fires channel A action, non-PWM modes only
// - Force B is one-cycle strobe, channel B
// - Forced compare sets no flag, no clear
// - Force bits always read back zero
// - Control B bits 5:4 read zero
// - Control B bit 3 is mode high bit
// - Clock select: stop or prescaled I/O clock
// - Codes six/seven: external falling/rising edge
// - External edges count whatever pin direction
// - Counter write blocks next compare match
// - Compares run continuously, drive flags, outputs
// - Compare B enable gates its interrupt
// - Compare A enable gates its interrupt
// - Overflow enable gates its interrupt
// - Compare B flag: set match, clear ack/one
// - Compare A flag: set match, clear ack/one
// - Overflow flag set per mode, write-one-clear
// - Mode table selects count sequence, top
// - Non-PWM output actions; force uses same
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_consts.vh"

module tmr8_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_timer_clock_pin,
  output reg         wave_out_a,
  output reg         wave_out_b,
  output reg         irq_compare_a,
  output reg         irq_compare_b,
  output reg         irq_overflow
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [7:0] count_r;
  reg [7:0] cmp_a_r;
  reg [7:0] cmp_b_r;
  reg [7:0] mask_r;
  reg [2:0] flags_r;
  reg       gie_r;
  reg       down_r;
  reg       block_r;
  reg [`TMR8_PRE_W-1:0] pre_r;
  reg       pin_s1_r;
  reg       pin_s2_r;
  reg       pin_d_r;

  wire [2:0] wave_mode_field;
  wire [2:0] clock_select_field;
  wire [1:0] output_a_action;
  wire [1:0] output_b_action;
  assign wave_mode_field    = {ctrl_b_r[`TMR8_B_WGM_HI], ctrl_a_r[1:0]};
  assign clock_select_field = ctrl_b_r[2:0];
  assign output_a_action    = ctrl_a_r[7:6];
  assign output_b_action    = ctrl_a_r[5:4];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc  = psel & penable & pready;
  wire wr   = acc & pwrite;
  wire map_ok = (paddr == `TMR8_OFF_CTRL_A) | (paddr == `TMR8_OFF_CTRL_B) |
                (paddr == `TMR8_OFF_COUNT)  | (paddr == `TMR8_OFF_CMP_A)  |
                (paddr == `TMR8_OFF_CMP_B)  | (paddr == `TMR8_OFF_MASK)   |
                (paddr == `TMR8_OFF_FLAGS)  | (paddr == `TMR8_OFF_GIE)    |
                (paddr == `TMR8_OFF_VACK);
  wire wr_ctrl_b = wr & (paddr == `TMR8_OFF_CTRL_B);
  wire wr_count  = wr & (paddr == `TMR8_OFF_COUNT);
  wire wr_flags  = wr & (paddr == `TMR8_OFF_FLAGS);
  wire wr_vack   = wr & (paddr == `TMR8_OFF_VACK);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  reg       is_pwm;
  reg       is_pc;
  reg [7:0] top;
  always @* begin
    is_pwm = 1'b0;
    is_pc  = 1'b0;
    top    = `TMR8_MAX;
    case (wave_mode_field)
      `TMR8_WM_NORMAL:   top = `TMR8_MAX;
      `TMR8_WM_CTC:      top = cmp_a_r;
      `TMR8_WM_PC_FF: begin
        is_pwm = 1'b1;
        is_pc  = 1'b1;
      end
      `TMR8_WM_PC_CMP: begin
        is_pwm = 1'b1;
        is_pc  = 1'b1;
        top    = cmp_a_r;
      end
      `TMR8_WM_FAST_FF:  is_pwm = 1'b1;
      `TMR8_WM_FAST_CMP: begin
        is_pwm = 1'b1;
        top    = cmp_a_r;
      end
      // Reserved modes count as normal so the counter never locks up
      default:           top = `TMR8_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock select and prescaler
  // ----------------------------------------------------------------
  // Pin passes two flops before any edge detection
  wire pin_rise = pin_s2_r & ~pin_d_r;
  wire pin_fall = ~pin_s2_r & pin_d_r;
  reg  tick;
  always @* begin
    tick = 1'b0;
    case (clock_select_field)
      `TMR8_CS_STOP:     tick = 1'b0;
      `TMR8_CS_DIV1:     tick = 1'b1;
      `TMR8_CS_DIV8:     tick = (pre_r[2:0] == 3'h7);
      `TMR8_CS_DIV64:    tick = (pre_r[5:0] == 6'h3F);
      `TMR8_CS_DIV256:   tick = (pre_r[7:0] == 8'hFF);
      `TMR8_CS_DIV1024:  tick = (pre_r == `TMR8_PRE_MAX);
      `TMR8_CS_EXT_FALL: tick = pin_fall;
      `TMR8_CS_EXT_RISE: tick = pin_rise;
      default:           tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter step and compare
  // ----------------------------------------------------------------
  wire match_a = (count_r == cmp_a_r) & ~block_r;
  wire match_b = (count_r == cmp_b_r) & ~block_r;
  reg [7:0] count_nxt;
  reg       down_nxt;
  reg       ovf_ev;
  always @* begin
    count_nxt = count_r;
    // Fresh direction outside dual-slope modes
    down_nxt  = is_pc & down_r;
    ovf_ev    = 1'b0;
    if (is_pc) begin
      if (!down_r) begin
        if (count_r >= top) begin
          down_nxt  = 1'b1;
          count_nxt = count_r - 8'h01;
        end else begin
          count_nxt = count_r + 8'h01;
        end
      end else if (count_r == `TMR8_BOTTOM) begin
        down_nxt  = 1'b0;
        count_nxt = 8'h01;
        ovf_ev    = 1'b1;
      end else begin
        count_nxt = count_r - 8'h01;
      end
    end else if (count_r == top) begin
      // Overflow at MAX in normal/CLEAR_ON_MATCH_MODE/fast FF, at TOP in fast OCRA
      count_nxt = `TMR8_BOTTOM;
      ovf_ev    = (wave_mode_field == `TMR8_WM_FAST_CMP) |
                  (count_r == `TMR8_MAX);
    end else begin
      // A counter above a compare top still wraps through MAX
      count_nxt = count_r + 8'h01;
      ovf_ev    = (count_r == `TMR8_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Force strobes
  // ----------------------------------------------------------------
  // Strobe lives only in the write cycle; nothing stores it
  wire force_a = wr_ctrl_b & pwdata[`TMR8_B_FOC_A] & ~is_pwm;
  wire force_b = wr_ctrl_b & pwdata[`TMR8_B_FOC_B] & ~is_pwm;

  // ----------------------------------------------------------------
  // Waveform action
  // ----------------------------------------------------------------
  function wave_act;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        `TMR8_ACT_TOGGLE: wave_act = ~cur;
        `TMR8_ACT_CLEAR:  wave_act = 1'b0;
        `TMR8_ACT_SET:    wave_act = 1'b1;
        default:          wave_act = cur;
      endcase
    end
  endfunction

  // PWM output: set/clear at up-count compare, opposite at down-count compare or fast-mode bottom
  function pwm_act;
    input [1:0] act;
    input       cur;
    input       hit;
    input       rst_pt;
    input       up;
    begin
      pwm_act = cur;
      if (act[1]) begin
        if (hit)
          pwm_act = act[0] ~^ up;
        else if (rst_pt)
          pwm_act = ~act[0];
      end
    end
  endfunction

  wire ev_a = tick & match_a;
  wire ev_b = tick & match_b;
  wire at_bottom = tick & ~is_pc & (count_nxt == `TMR8_BOTTOM);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Taken in the setup cycle so it stands together with pready
  reg [31:0] prdata_nxt;
  always @* begin
    prdata_nxt = 32'h00000000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TMR8_OFF_CTRL_A: prdata_nxt[7:0] = ctrl_a_r & `TMR8_CTRLA_RMASK;
        `TMR8_OFF_CTRL_B:
          prdata_nxt[7:0] = ctrl_b_r & `TMR8_CTRLB_RMASK;
        `TMR8_OFF_COUNT:  prdata_nxt[7:0] = count_r;
        `TMR8_OFF_CMP_A:  prdata_nxt[7:0] = cmp_a_r;
        `TMR8_OFF_CMP_B:  prdata_nxt[7:0] = cmp_b_r;
        `TMR8_OFF_MASK:   prdata_nxt[7:0] = mask_r & `TMR8_IRQ_RMASK;
        `TMR8_OFF_FLAGS:  prdata_nxt[7:0] = {5'h00, flags_r};
        `TMR8_OFF_GIE:    prdata_nxt[0]   = gie_r;
        default:          prdata_nxt      = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Third flop only remembers the last synchronised level for edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= ext_timer_clock_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Bit order follows the flag register: compare B, compare A, overflow
  wire [2:0] flag_set_w;
  wire [2:0] flag_clr_w;
  // Forced strobes never reach flag_set_w, so they raise no flag
  assign flag_set_w = {ev_b, ev_a, tick & ovf_ev};
  // Vector acknowledge stands in for the hardware clear on entry
  assign flag_clr_w = (wr_flags | wr_vack) ? pwdata[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      // Set wins over clear so an event in the clear cycle is kept
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          flags_r[gi] <= 1'b0;
        else
          flags_r[gi] <= flag_set_w[gi] |
                         (flags_r[gi] & ~flag_clr_w[gi]);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r   <= `TMR8_RST_BYTE;
      ctrl_b_r   <= `TMR8_RST_BYTE;
      count_r    <= `TMR8_RST_BYTE;
      cmp_a_r    <= `TMR8_RST_BYTE;
      cmp_b_r    <= `TMR8_RST_BYTE;
      mask_r     <= `TMR8_RST_BYTE;
      gie_r      <= 1'b0;
      down_r     <= 1'b0;
      block_r    <= 1'b0;
      pre_r      <= {`TMR8_PRE_W{1'b0}};
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq_compare_a <= 1'b0;
      irq_compare_b <= 1'b0;
      irq_overflow  <= 1'b0;
    end else begin
      // Free-running prescaler; not reset by mode changes
      pre_r    <= pre_r + {{(`TMR8_PRE_W-1){1'b0}}, 1'b1};

      // No wait state: pready rises in the first access cycle
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_ok;
      prdata  <= prdata_nxt;

      if (wr & (paddr == `TMR8_OFF_CTRL_A))
        ctrl_a_r <= pwdata[7:0] & `TMR8_CTRLA_RMASK;
      if (wr_ctrl_b)
        ctrl_b_r <= pwdata[7:0] & `TMR8_CTRLB_RMASK;
      if (wr & (paddr == `TMR8_OFF_CMP_A))
        cmp_a_r <= pwdata[7:0];
      if (wr & (paddr == `TMR8_OFF_CMP_B))
        cmp_b_r <= pwdata[7:0];
      if (wr & (paddr == `TMR8_OFF_MASK))
        mask_r <= pwdata[7:0] & `TMR8_IRQ_RMASK;
      if (wr & (paddr == `TMR8_OFF_GIE))
        gie_r <= pwdata[0];

      // Software write wins over a tick and blocks the next match
      if (wr_count) begin
        count_r <= pwdata[7:0];
        block_r <= 1'b1;
      end else if (tick) begin
        count_r <= count_nxt;
        down_r  <= down_nxt;
        block_r <= 1'b0;
      end

      // Registered gating costs one cycle of interrupt latency
      irq_compare_b <= gie_r & mask_r[`TMR8_BIT_CMPB] &
                       flags_r[`TMR8_BIT_CMPB];
      irq_compare_a <= gie_r & mask_r[`TMR8_BIT_CMPA] &
                       flags_r[`TMR8_BIT_CMPA];
      irq_overflow  <= gie_r & mask_r[`TMR8_BIT_OVF] &
                       flags_r[`TMR8_BIT_OVF];

      if (!is_pwm) begin
        if (force_a | ev_a)
          wave_out_a <= wave_act(output_a_action, wave_out_a);
        if (force_b | ev_b)
          wave_out_b <= wave_act(output_b_action, wave_out_b);
      end else begin
        wave_out_a <= pwm_act(output_a_action, wave_out_a,
                              ev_a & (cmp_a_r != top), at_bottom, ~down_r);
        wave_out_b <= pwm_act(output_b_action, wave_out_b,
                              ev_b, at_bottom, ~down_r);
      end
    end
  end

endmodule

`default_nettype wire

// ==== tmr8_props.sv ====
/*
  Checker for the 8-bit timer: read-back of control B, interrupt
  gating by the mask and forced compare actions.
  Assumes the APB slave of tmr8_timer and its register offsets.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_consts.vh"
module tmr8_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_timer_clock_pin,
  input wire logic        wave_out_a,
  input wire logic        wave_out_b,
  input wire logic        irq_compare_a,
  input wire logic        irq_compare_b,
  input wire logic        irq_overflow
);
  // ------------------------------------------------------------
  // Shadow of control writes
  // ------------------------------------------------------------
  logic [7:0] ca_r;
  logic [3:0] cb_r;
  wire        acc = psel && penable && pready;
  wire        wok = acc && pwrite;
  wire        rdb = acc && !pwrite && paddr == `TMR8_OFF_CTRL_B;
  wire        mkw = wok && paddr == `TMR8_OFF_MASK;
  // Even low mode bit means a non-PWM mode, reserved ones included
  wire        frc = wok && paddr == `TMR8_OFF_CTRL_B && !ca_r[0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca_r <= 8'h00;
      cb_r <= 4'h0;
    end else if (wok && paddr == `TMR8_OFF_CTRL_A) begin
      ca_r <= pwdata[7:0];
    end else if (wok && paddr == `TMR8_OFF_CTRL_B) begin
      cb_r <= pwdata[3:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_foc_rd; rdb |-> prdata[7:6] == 2'h0; endproperty
  a_foc_rd: assert property (p_foc_rd)
    else $error("force bits read back nonzero");
  property p_res_rd; rdb |-> prdata[5:4] == 2'h0; endproperty
  a_res_rd: assert property (p_res_rd)
    else $error("reserved control bits read nonzero");
  property p_cb_rd; rdb |-> prdata[3:0] == cb_r; endproperty
  a_cb_rd: assert property (p_cb_rd)
    else $error("mode bit or clock select lost");
  property p_ena_b; mkw && !pwdata[2] |=> ##1 !irq_compare_b; endproperty
  a_ena_b: assert property (p_ena_b)
    else $error("compare b interrupt not masked");
  property p_ena_a; mkw && !pwdata[1] |=> ##1 !irq_compare_a; endproperty
  a_ena_a: assert property (p_ena_a)
    else $error("compare a interrupt not masked");
  property p_ena_o; mkw && !pwdata[0] |=> ##1 !irq_overflow; endproperty
  a_ena_o: assert property (p_ena_o)
    else $error("overflow interrupt not masked");
  property p_frc_a;
    frc && pwdata[7] && ca_r[7] |-> ##[1:2] wave_out_a == ca_r[6];
  endproperty
  a_frc_a: assert property (p_frc_a)
    else $error("forced compare a gave wrong level");
  property p_frc_b;
    frc && pwdata[6] && ca_r[5] |-> ##[1:2] wave_out_b == ca_r[4];
  endproperty
  a_frc_b: assert property (p_frc_b)
    else $error("forced compare b gave wrong level");
endmodule
bind tmr8_timer tmr8_props tmr8_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .ext_timer_clock_pin(ext_timer_clock_pin),
  .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
  .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
  .irq_overflow(irq_overflow)
);
`default_nettype wire

// ==== test_tmr8_timer.sv ====
/*
  Self-checking bench for the 8-bit timer over APB.
  Assumes the design register map and a 100 MHz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_consts.vh"
module test_tmr8_timer;
  logic        pclk, presetn, psel, penable, pwrite, pin, pready, pslverr;
  logic        wa, wb, ia, ib, io, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, sv;
  int          bad_count, check_count;
  localparam logic [11:0] CA = `TMR8_OFF_CTRL_A, CB = `TMR8_OFF_CTRL_B;
  localparam logic [11:0] CN = `TMR8_OFF_COUNT, OA = `TMR8_OFF_CMP_A;
  localparam logic [11:0] OB = `TMR8_OFF_CMP_B, MK = `TMR8_OFF_MASK;
  localparam logic [11:0] FL = `TMR8_OFF_FLAGS, GE = `TMR8_OFF_GIE;
  localparam logic [11:0] VA = `TMR8_OFF_VACK;
  tmr8_timer tmr8_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_timer_clock_pin(pin),
    .wave_out_a(wa), .wave_out_b(wb), .irq_compare_a(ia),
    .irq_compare_b(ib), .irq_overflow(io)
  );
  always #5 pclk = ~pclk;
  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One idle edge after release so the next setup never collides
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rdv, e);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [11:0] rs [6] = '{CB, CN, OA, OB, MK, FL};
    foreach (rs[i]) rchk("reset value", rs[i], 0);
    wr(CB, 8'hFF);
    rchk("ctrl_b read", CB, 32'h0F);
    wr(CB, 8'h00);
    apb(1'b0, 12'h0FC, 8'h00);
    chk("unmapped err", err, 1);
    wr(MK, 8'hFF);
    rchk("mask read", MK, 32'h07);
    $display("t_regs done");
  endtask
  task automatic t_force;
    logic [7:0] ac [3] = '{8'hF0, 8'hA0, 8'h50};
    logic [2:0] ex = 3'b101;
    foreach (ac[i]) begin
      wr(CA, ac[i]);
      wr(CB, 8'hC0);
      chk("force a", wa, ex[2-i]);
      chk("force b", wb, ex[2-i]);
    end
    rchk("no flag", FL, 0);
    rchk("strobe read", CB, 0);
    wr(CA, 8'hA3);
    wr(CB, 8'hC0);
    chk("pwm ignores a", wa, 1);
    chk("pwm ignores b", wb, 1);
    wr(CA, 8'h02);
    wr(CN, 8'h33);
    wr(OA, 8'h33);
    wr(CB, 8'h80);
    rchk("ctc no clear", CN, 32'h33);
    $display("t_force done");
  endtask
  task automatic t_count;
    int dv [5] = '{1, 8, 64, 256, 1024};
    wr(CA, 8'h00);
    wr(OA, 8'h05);
    wr(OB, 8'h03);
    wr(CN, 8'h00);
    wr(GE, 8'h00);
    wr(CB, 8'h01);
    cyc(20);
    wr(CB, 8'h00);
    rchk("match flags", FL, 32'h06);
    chk("gie off", ia, 0);
    wr(GE, 8'h01);
    cyc(2);
    chk("irq a", ia, 1);
    chk("irq b", ib, 1);
    wr(FL, 8'h02);
    rchk("w1c a", FL, 32'h04);
    wr(VA, 8'h04);
    rchk("ack b", FL, 0);
    wr(CN, 8'hFA);
    wr(CB, 8'h01);
    cyc(16);
    wr(CB, 8'h00);
    rchk("overflow", FL, 32'h07);
    chk("irq ovf", io, 1);
    wr(FL, 8'h00);
    rchk("write zero", FL, 32'h07);
    wr(MK, 8'h00);
    cyc(2);
    chk("ovf masked", io, 0);
    wr(VA, 8'h01);
    rchk("ack ovf", FL, 32'h06);
    wr(FL, 8'h06);
    wr(OA, 8'h40);
    wr(CN, 8'h40);
    wr(CB, 8'h01);
    rchk("blocked match", FL, 0);
    wr(CB, 8'h00);
    foreach (dv[i]) begin
      wr(CN, 8'h00);
      wr(CB, 8'(i + 1));
      cyc(10 * dv[i]);
      wr(CB, 8'h00);
      apb(1'b0, CN, 8'h00);
      chk("rate", rdv >= 9 && rdv <= 14, 1);
    end
    sv = rdv;
    cyc(5);
    rchk("stopped", CN, sv);
    $display("t_count done");
  endtask
  // 23 ticks at div 1: CLEAR_ON_MATCH_MODE top 7 wraps to 7, dual slope FD ends at EA
  task automatic t_modes;
    wr(FL, 8'h07);
    wr(CA, 8'h02);
    wr(OA, 8'h07);
    wr(CN, 8'h00);
    wr(CB, 8'h01);
    cyc(20);
    wr(CB, 8'h00);
    rchk("ctc wrap", CN, 32'h07);
    rchk("ctc flags", FL, 32'h06);
    wr(CA, 8'h01);
    wr(CN, 8'hFD);
    wr(CB, 8'h01);
    cyc(20);
    wr(CB, 8'h00);
    rchk("phase correct", CN, 32'hEA);
    wr(CA, 8'h00);
    $display("t_modes done");
  endtask
  task automatic t_ext;
    wr(CN, 8'h00);
    wr(CB, 8'h07);
    repeat (5) begin
      pin <= 1'b1;
      cyc(4);
      pin <= 1'b0;
      cyc(4);
    end
    rchk("rising edges", CN, 5);
    wr(CB, 8'h06);
    wr(CN, 8'h00);
    repeat (3) begin
      pin <= 1'b1;
      cyc(4);
      pin <= 1'b0;
      cyc(4);
    end
    rchk("falling edges", CN, 3);
    wr(CB, 8'h00);
    $display("t_ext done");
  endtask
  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pin = 0;
    bad_count = 0;
    check_count = 0;
    cyc(6);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_force;
    t_count;
    t_modes;
    t_ext;
    conclude;
  end
  initial begin
    #500000;
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
